/* File: rtl/dram_mode_regs.svh */
// Register offsets, field positions, reset values and timing counts of the mode decoder
`ifndef DRAM_MODE_REGS_SVH
`define DRAM_MODE_REGS_SVH

`define MODE_STAGE_OFS      12'h000
`define MODE_LOAD_OFS       12'h004
`define MODE_ACTIVE_OFS     12'h008
`define MODE_STATUS_OFS     12'h00C

`define FLD_LATCH_MODE      0
`define FLD_WCAS_DELAY      1
`define FLD_ROW_HOLD        2
`define FLD_COL_SETUP       3
`define FLD_CFG_LO          4
`define FLD_CFG_HI          6
`define FLD_LOAD_GO         0
`define MODE_RESET_VAL      7'h00

`define CLK_PERIOD_NS       50
`define ROW_HOLD_LONG_NS    25
`define ROW_HOLD_SHORT_NS   15
`define COL_SETUP_LONG_NS   10
`define COL_SETUP_SHORT_NS  0
`define MIN_CYC(ns) (((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1) ? 1 : \
                     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define ROW_HOLD_LONG_CYC   `MIN_CYC(`ROW_HOLD_LONG_NS)
`define ROW_HOLD_SHORT_CYC  `MIN_CYC(`ROW_HOLD_SHORT_NS)
`define COL_SETUP_LONG_CYC  `MIN_CYC(`COL_SETUP_LONG_NS)
`define COL_SETUP_SHORT_CYC `MIN_CYC(`COL_SETUP_SHORT_NS)
`define DELAY_LINE_CYC      1

`endif

/* File: rtl/dram_mode_pkg.sv */
// Types shared by the mode decoder modules
package dram_mode_pkg;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ROW, SEQ_COL, SEQ_CAS} seq_state_e;
    typedef logic [2:0] cfg_code_t;
    typedef logic [3:0] cyc_t;
    typedef logic [3:0] strobe_t;
endpackage : dram_mode_pkg

/* File: rtl/strobe_select_decode.sv */
// Strobe selection and scrub decode from the configuration code and bank inputs
`timescale 1ns/100ps
module strobe_select_decode
    import dram_mode_pkg::*;
(
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire cfg_code_t strobe_config_code,
    input  wire logic      bank_sel_high,
    input  wire logic      bank_sel_low,
    output logic [3:0]     ras_sel,
    output logic [3:0]     cas_sel,
    output logic           refresh_scrub
);
    // Strobe pattern for one code and bank pair
    function automatic strobe_t sel_of(input cfg_code_t c, input logic hi, input logic lo);
        strobe_t s;
        s = 4'hF;
        unique case (c)
            3'h0: s = 4'hF;                                         // RL7
            3'h1: s = hi ? 4'hC : 4'h3;                             // RL9
            3'h2: s = strobe_t'(4'h1 << {hi, lo});                  // RL10 RL11
            default: s = 4'hF;
        endcase
        return s;
    endfunction : sel_of

    // Decode used for both strobe groups and scrub
    always_comb begin
        ras_sel       = sel_of(strobe_config_code, bank_sel_high, bank_sel_low);
        cas_sel       = sel_of(strobe_config_code, bank_sel_high, bank_sel_low);
        refresh_scrub = (strobe_config_code <= 3'h2);               // RL7 RL9
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    all_select_a:   assert property (strobe_config_code == 3'h0 |->
                        ras_sel == 4'hF && cas_sel == 4'hF && refresh_scrub) // RL7
                        else $error("code 000 must select all strobes and scrub");
    pair_select_a:  assert property (strobe_config_code == 3'h1 |->
                        ras_sel == (bank_sel_high ? 4'hC : 4'h3) && refresh_scrub) // RL9
                        else $error("code 001 pair select wrong");
    single_select_a: assert property (strobe_config_code == 3'h2 && bank_sel_high
                        && !bank_sel_low |-> ras_sel == 4'h4 && $onehot(cas_sel)) // RL11
                        else $error("code 010 single select wrong");
    single_onehot_a: assert property (strobe_config_code == 3'h2 |-> $onehot(ras_sel)) // RL10
                        else $error("code 010 must select one strobe pair");
endmodule : strobe_select_decode

/* File: rtl/access_timing_seq.sv */
// RAS, address phase and CAS timing for one access
`timescale 1ns/100ps
module access_timing_seq
    import dram_mode_pkg::*;
#(
    parameter int DELAY_LINE_CYC = 1
)(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic access_req,
    input  wire logic write_access,
    input  wire logic write_cas_delay_sel,
    input  wire cyc_t row_hold_cyc,
    input  wire cyc_t col_setup_cyc,
    output logic      ras_on,
    output logic      addr_col,
    output logic      cas_on
);
    localparam cyc_t DLY = cyc_t'(DELAY_LINE_CYC);

    if (DELAY_LINE_CYC < 1 || DELAY_LINE_CYC > 15) begin : g_bad_dly
        $error("DELAY_LINE_CYC must lie in 1..15");
    end

    seq_state_e state_ff;
    seq_state_e nxt_state;
    cyc_t       phase_cnt_ff;
    cyc_t       ras_age_ff;
    logic       wr_dly;
    logic       cas_ok;

    // Write delay waits for both the delay line and the first edge after RAS
    assign wr_dly = write_access && write_cas_delay_sel;                          // RL3
    assign cas_ok = (phase_cnt_ff >= col_setup_cyc)
                  && (!wr_dly || (ras_age_ff >= DLY && ras_age_ff >= 4'h1));      // RL4

    // Next state
    always_comb begin
        nxt_state = state_ff;
        if (!access_req) begin
            nxt_state = SEQ_IDLE;
        end else begin
            unique case (state_ff)
                SEQ_IDLE: nxt_state = SEQ_ROW;
                SEQ_ROW:  if (phase_cnt_ff >= row_hold_cyc) nxt_state = SEQ_COL;  // RL5
                SEQ_COL:  if (cas_ok) nxt_state = SEQ_CAS;                        // RL6
                SEQ_CAS:  nxt_state = SEQ_CAS;
            endcase
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= SEQ_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Cycles spent in the current phase, restart on each phase change
    always_ff @(posedge aclk) begin
        if (!aresetn || nxt_state != state_ff) begin
            phase_cnt_ff <= 4'h1;
        end else if (phase_cnt_ff != 4'hF) begin
            phase_cnt_ff <= phase_cnt_ff + 4'h1;
        end
    end

    // Cycles since RAS went active
    always_ff @(posedge aclk) begin
        if (!aresetn || state_ff == SEQ_IDLE) begin
            ras_age_ff <= 4'h0;
        end else if (ras_age_ff != 4'hF) begin
            ras_age_ff <= ras_age_ff + 4'h1;
        end
    end

    assign ras_on   = (state_ff != SEQ_IDLE);
    assign addr_col = (state_ff == SEQ_COL) || (state_ff == SEQ_CAS);
    assign cas_on   = (state_ff == SEQ_CAS);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence col_phase_s;
        $rose(addr_col);
    endsequence
    sequence cas_start_s;
        $rose(cas_on);
    endsequence

    row_hold_a:   assert property (col_phase_s |-> ras_age_ff >= row_hold_cyc) // RL5
                      else $error("row address left too early after RAS");
    col_setup_a:  assert property (cas_start_s |-> $past(addr_col)
                      && $past(phase_cnt_ff) >= col_setup_cyc) // RL6
                      else $error("column address setup too short");
    same_cas_a:   assert property (!write_cas_delay_sel && state_ff == SEQ_COL
                      && phase_cnt_ff == col_setup_cyc && access_req |=> cas_on) // RL3
                      else $error("CAS timing differs between read and write");
    write_delay_a: assert property (cas_start_s and $past(wr_dly) |->
                      $past(ras_age_ff) >= DLY && $past(ras_age_ff) >= 4'h1) // RL4
                      else $error("delayed write CAS came too early");
endmodule : access_timing_seq

/* File: rtl/dram_ctrl_mode_bit_decode.sv */
// Mode word registers over AXI4-Lite, address latches and strobe generation
//
// Notes on behaviour
// RL1: Latch mode 0 captures row, column, bank on strobe, latch enable, granted B.
// RL2: Latch mode 1 makes row, column and bank latches transparent.
// RL3: Write CAS delay 0 gives identical CAS timing for reads and writes.
// RL4: Write CAS delay 1 waits for delay line and first edge after RAS.
// RL5: Row hold select gives 25 ns at 0, 15 ns at 1 after RAS.
// RL6: Column setup select gives 10 ns at 0, 0 ns at 1 before CAS.
// RL7: Code 000 selects all strobes, ignores banks, scrubs during refresh.
// RL8: A selected CAS asserts only while its lane extend input is asserted.
// RL9: Code 001: upper bank picks pair 0-1 or 2-3; scrubbing on.
// RL10: Code 010: both bank inputs select one RAS and CAS pair.
// RL11: Single select: banks 00, 01, 10, 11 select pairs 0 to 3.
// RL12: Active mode settings stay unchanged until the next mode load.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "dram_mode_regs.svh"
module dram_ctrl_mode_bit_decode
    import dram_mode_pkg::*;
#(
    parameter int ADDR_W         = 11,
    parameter int DELAY_LINE_CYC = `DELAY_LINE_CYC
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              port_a_addr_strobe,
    input  wire logic              port_a_latch_enable,
    input  wire logic              port_b_access_request,
    input  wire logic              port_b_grant,
    input  wire logic [ADDR_W-1:0] row_addr_in,
    input  wire logic [ADDR_W-1:0] col_addr_in,
    input  wire logic              bank_sel_high,
    input  wire logic              bank_sel_low_or_latch_mode,
    input  wire logic              access_req,
    input  wire logic              write_access,
    input  wire logic [3:0]        byte_lane_cas_extend_n,
    output logic [3:0]             ras_out_n,
    output logic [3:0]             cas_out_n,
    output logic [ADDR_W-1:0]      dram_addr,
    output logic                   refresh_scrub
);
    if (ADDR_W < 9 || ADDR_W > 12) begin : g_bad_addr
        $error("ADDR_W must lie in 9..12");
    end

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    logic [6:0]        stage_ff;
    logic [6:0]        active_ff;
    logic              load_pulse;
    logic [11:0]       awaddr_ff;
    logic              aw_held_ff;
    logic [31:0]       wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              w_held_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        rresp_ff;
    logic              do_write;
    logic [ADDR_W-1:0] row_ff;
    logic [ADDR_W-1:0] col_ff;
    logic [1:0]        bank_ff;
    logic [ADDR_W-1:0] row_q;
    logic [ADDR_W-1:0] col_q;
    logic [1:0]        bank_q;
    logic              capture;
    logic              latch_mode;
    cyc_t              row_hold_cyc;
    cyc_t              col_setup_cyc;
    logic [3:0]        ras_sel;
    logic [3:0]        cas_sel;
    logic              scrub;
    logic              ras_on;
    logic              cas_on;
    logic              addr_col;
    logic [3:0]        ras_n_ff;
    logic [3:0]        cas_n_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic              scrub_ff;

    // Known register offsets
    function automatic logic is_mapped(input logic [11:0] a);
        return a == `MODE_STAGE_OFS || a == `MODE_LOAD_OFS
            || a == `MODE_ACTIVE_OFS || a == `MODE_STATUS_OFS;
    endfunction : is_mapped

    // Write address channel holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    // Write data channel holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready  = !w_held_ff;
    assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Staged mode word, fields sit in byte lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_ff <= `MODE_RESET_VAL;
        end else if (do_write && awaddr_ff == `MODE_STAGE_OFS && wstrb_ff[0]) begin
            stage_ff <= wdata_ff[6:0];
        end
    end

    // Mode load sequence commits the staged word
    assign load_pulse = do_write && awaddr_ff == `MODE_LOAD_OFS && wstrb_ff[0]
                      && wdata_ff[`FLD_LOAD_GO];

    // Active mode word kept until the next load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_ff <= `MODE_RESET_VAL;
        end else if (load_pulse) begin
            active_ff <= stage_ff;                                           // RL12
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                `MODE_STAGE_OFS:  rdata_ff <= {25'h0, stage_ff};
                `MODE_ACTIVE_OFS: rdata_ff <= {25'h0, active_ff};
                `MODE_STATUS_OFS: rdata_ff <= {24'h0, scrub_ff, cas_on, ras_on,
                                               addr_col, bank_q, 2'h0};
                default:          rdata_ff <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    // Mode field decode
    assign latch_mode    = active_ff[`FLD_LATCH_MODE];
    assign row_hold_cyc  = active_ff[`FLD_ROW_HOLD] ? cyc_t'(`ROW_HOLD_SHORT_CYC)
                                                    : cyc_t'(`ROW_HOLD_LONG_CYC);   // RL5
    assign col_setup_cyc = active_ff[`FLD_COL_SETUP] ? cyc_t'(`COL_SETUP_SHORT_CYC)
                                                     : cyc_t'(`COL_SETUP_LONG_CYC); // RL6

    // Capture events for the input latches
    assign capture = port_a_addr_strobe || port_a_latch_enable
                   || (port_b_access_request && port_b_grant);

    // Input address and bank latches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_ff  <= '0;
            col_ff  <= '0;
            bank_ff <= 2'h0;
        end else if (!latch_mode && capture) begin
            row_ff  <= row_addr_in;                                          // RL1
            col_ff  <= col_addr_in;
            bank_ff <= {bank_sel_high, bank_sel_low_or_latch_mode};
        end
    end

    // Fall-through path when latches are transparent
    assign row_q  = latch_mode ? row_addr_in : row_ff;                       // RL2
    assign col_q  = latch_mode ? col_addr_in : col_ff;
    assign bank_q = latch_mode ? {bank_sel_high, bank_sel_low_or_latch_mode} : bank_ff;

    strobe_select_decode u_decode (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .strobe_config_code (cfg_code_t'(active_ff[`FLD_CFG_HI:`FLD_CFG_LO])),
        .bank_sel_high      (bank_q[1]),
        .bank_sel_low       (bank_q[0]),
        .ras_sel            (ras_sel),
        .cas_sel            (cas_sel),
        .refresh_scrub      (scrub)
    );

    access_timing_seq #(
        .DELAY_LINE_CYC (DELAY_LINE_CYC)
    ) u_seq (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .access_req          (access_req),
        .write_access        (write_access),
        .write_cas_delay_sel (active_ff[`FLD_WCAS_DELAY]),
        .row_hold_cyc        (row_hold_cyc),
        .col_setup_cyc       (col_setup_cyc),
        .ras_on              (ras_on),
        .addr_col            (addr_col),
        .cas_on              (cas_on)
    );

    // Registered DRAM strobes and address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ras_n_ff <= 4'hF;
            cas_n_ff <= 4'hF;
            addr_ff  <= '0;
            scrub_ff <= 1'b0;
        end else begin
            ras_n_ff <= ~({4{ras_on}} & ras_sel);
            cas_n_ff <= ~({4{cas_on}} & cas_sel & ~byte_lane_cas_extend_n);  // RL8
            addr_ff  <= addr_col ? col_q : row_q;
            scrub_ff <= scrub;
        end
    end

    assign ras_out_n     = ras_n_ff;
    assign cas_out_n     = cas_n_ff;
    assign dram_addr     = addr_ff;
    assign refresh_scrub = scrub_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    latch_capture_a: assert property (!latch_mode && capture |=>
                         row_ff == $past(row_addr_in) && col_ff == $past(col_addr_in)) // RL1
                         else $error("latched address not captured");
    latch_hold_a:    assert property (!latch_mode && !capture |=> $stable(row_ff)
                         && $stable(bank_ff)) // RL1
                         else $error("latch changed without capture event");
    fall_through_a:  assert property (latch_mode |-> row_q == row_addr_in
                         && bank_q == {bank_sel_high, bank_sel_low_or_latch_mode}) // RL2
                         else $error("transparent latch not passing inputs");
    cas_extend_a:    assert property (##1 !cas_out_n[0] |->
                         !$past(byte_lane_cas_extend_n[0]) && $past(cas_on)) // RL8
                         else $error("CAS asserted without lane extend");
    mode_retain_a:   assert property (!load_pulse |=> $stable(active_ff)) // RL12
                         else $error("mode changed without a load");
    mode_load_a:     assert property (load_pulse |=> active_ff == $past(stage_ff)) // RL12
                         else $error("mode load did not take staged word");
endmodule : dram_ctrl_mode_bit_decode

/* File: verification/dram_array_model.sv */
// Behavioural DRAM array that records the address seen at each RAS and CAS falling edge
`timescale 1ns/100ps
module dram_array_model #(
    parameter int AW = 11
)(
    input  wire logic          aclk,
    input  wire logic [3:0]    ras_out_n,
    input  wire logic [3:0]    cas_out_n,
    input  wire logic [AW-1:0] dram_addr,
    output logic [AW-1:0]      row_q,
    output logic [AW-1:0]      col_q,
    output int                 gap_q
);
    logic [3:0] ras_prev_ff;
    logic [3:0] cas_prev_ff;
    int         cnt_ff;
    // Row taken as RAS falls, column and RAS to CAS distance as CAS falls
    always_ff @(posedge aclk) begin
        ras_prev_ff <= ras_out_n;
        cas_prev_ff <= cas_out_n;
        cnt_ff      <= cnt_ff + 1;
        if (ras_prev_ff === 4'hF && ras_out_n !== 4'hF) begin
            row_q  <= dram_addr;
            cnt_ff <= 0;
        end
        if (cas_prev_ff === 4'hF && cas_out_n !== 4'hF) begin
            col_q <= dram_addr;
            gap_q <= cnt_ff + 1;
        end
    end
endmodule : dram_array_model

/* File: verification/dram_ctrl_mode_bit_decode_bench.sv */
// Self-checking bench for the mode word decoder
`timescale 1ns/100ps
`include "dram_mode_regs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %0h got %0h", nm, e, g); n_errors++; end end
module dram_ctrl_mode_bit_decode_bench;
    import dram_mode_pkg::*;
    localparam int DL = 3;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, port_a_addr_strobe, port_a_latch_enable, port_b_access_request;
    logic        port_b_grant, bank_sel_high, bank_sel_low_or_latch_mode, access_req;
    logic        write_access, refresh_scrub;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb, byte_lane_cas_extend_n, ras_out_n, cas_out_n, rs, cs, sel;
    logic [10:0] row_addr_in, col_addr_in, dram_addr, p_row, p_col;
    int          p_gap, n_errors, num_checks;

    dram_ctrl_mode_bit_decode #(.DELAY_LINE_CYC(DL)) i_dram_ctrl_mode_bit_decode (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_addr_strobe, .port_a_latch_enable,
        .port_b_access_request, .port_b_grant, .row_addr_in, .col_addr_in, .bank_sel_high,
        .bank_sel_low_or_latch_mode, .access_req, .write_access, .byte_lane_cas_extend_n,
        .ras_out_n, .cas_out_n, .dram_addr, .refresh_scrub);
    dram_array_model #(.AW(11)) i_dram_array_model (.aclk, .ras_out_n, .cas_out_n,
        .dram_addr, .row_q(p_row), .col_q(p_col), .gap_q(p_gap));

    // Clock at 50 ns period
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // AXI4-Lite write, waits for the response under a bound
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge aclk);
            if (s_axi_bvalid) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (k == 20) begin n_errors++; conclude(); end
        `CHK("bresp", er, s_axi_bresp)
    endtask : axw

    // AXI4-Lite read with expected data and response
    task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (k == 20) begin n_errors++; conclude(); end
        `CHK("rresp", er, s_axi_rresp)
        `CHK("rdata", ed, s_axi_rdata)
    endtask : axr

    task automatic setm(input logic [6:0] m);
        axw(`MODE_STAGE_OFS, {25'h0, m}, 2'h0);
        axw(`MODE_LOAD_OFS, 32'h1, 2'h0);
    endtask : setm

    // One access held past the CAS walk, strobes sampled before release
    task automatic access(input logic w);
        access_req <= 1'b1; write_access <= w;
        repeat (8) @(posedge aclk);
        rs = ras_out_n; cs = cas_out_n;
        access_req <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : access

    initial begin
        n_errors = 0; num_checks = 0; aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready} = 2'h3; // Answers always accepted
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {port_a_addr_strobe, port_a_latch_enable, port_b_access_request, port_b_grant} = '0;
        {bank_sel_high, bank_sel_low_or_latch_mode, access_req, write_access} = '0;
        row_addr_in = '0; col_addr_in = '0; byte_lane_cas_extend_n = 4'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // Register map, unmapped place, staging without load
        axr(`MODE_ACTIVE_OFS, 32'h0, 2'h0);
        axr(12'h010, 32'h0, 2'h2);
        axw(12'h010, 32'h1, 2'h2);
        axw(`MODE_STAGE_OFS, 32'h7F, 2'h0);
        axr(`MODE_STAGE_OFS, 32'h7F, 2'h0);
        axr(`MODE_ACTIVE_OFS, 32'h0, 2'h0);
        // Strobe selection for codes 000 to 011 and every bank pair, latches transparent
        for (int c = 0; c < 4; c++) begin
            for (int b = 0; b < 4; b++) begin
                setm({3'(c), 4'h1});
                bank_sel_high <= b[1]; bank_sel_low_or_latch_mode <= b[0];
                access(1'b0);
                sel = (c == 1) ? (b[1] ? 4'hC : 4'h3) : (c == 2) ? 4'(1 << b) : 4'hF;
                `CHK("ras", ~sel, rs)
                `CHK("cas", ~sel, cs)
                `CHK("scrub", (c < 3), refresh_scrub)
            end
        end
        // Lane extend gating
        setm(7'h01);
        byte_lane_cas_extend_n <= 4'b0101;
        access(1'b0);
        `CHK("cas_lane", 4'b0101, cs)
        byte_lane_cas_extend_n <= 4'h0;
        // Row hold and column setup settings, reads and writes alike
        for (int m = 0; m < 4; m++) begin
            setm({3'h0, 2'(m), 2'h1});
            access(1'b0);
            `CHK("gap_rd", 2, p_gap)
            access(1'b1);
            `CHK("gap_wr", 2, p_gap)
        end
        // Delayed CAS on writes only
        setm(7'h03);
        access(1'b1);
        `CHK("gap_wdly", 1'b1, (p_gap >= DL))
        access(1'b0);
        `CHK("gap_rdly", 2, p_gap)
        // Capture events in latch mode 0; request without grant does not capture
        setm(7'h00);
        for (int e = 0; e < 4; e++) begin
            row_addr_in <= 11'h100 + 11'(e); col_addr_in <= 11'h200 + 11'(e);
            port_a_addr_strobe <= (e == 0); port_a_latch_enable <= (e == 1);
            port_b_access_request <= (e >= 2); port_b_grant <= (e == 2);
            @(posedge aclk);
            {port_a_addr_strobe, port_a_latch_enable, port_b_access_request} <= '0;
            port_b_grant <= 1'b0; row_addr_in <= 11'h7FF; col_addr_in <= 11'h000;
            @(posedge aclk);
            access(1'b0);
            `CHK("row_cap", 11'h100 + 11'((e == 3) ? 2 : e), p_row)
            `CHK("col_cap", 11'h200 + 11'((e == 3) ? 2 : e), p_col)
        end
        // Transparent latches follow the inputs
        setm(7'h01);
        row_addr_in <= 11'h155; col_addr_in <= 11'h2AA;
        access(1'b0);
        `CHK("row_thru", 11'h155, p_row)
        `CHK("col_thru", 11'h2AA, p_col)
        // Active word kept until the next load
        axw(`MODE_STAGE_OFS, 32'h7F, 2'h0);
        axr(`MODE_ACTIVE_OFS, 32'h1, 2'h0);
        axw(`MODE_LOAD_OFS, 32'h1, 2'h0);
        axr(`MODE_ACTIVE_OFS, 32'h7F, 2'h0);
        axr(`MODE_LOAD_OFS, 32'h0, 2'h0);
        axr(`MODE_STATUS_OFS, 32'hC, 2'h0);
        repeat (2) @(posedge aclk);
        `CHK("scrub_off", 1'b0, refresh_scrub)
        conclude();
    end
endmodule : dram_ctrl_mode_bit_decode_bench
